// File: fpm_menu_ctrl.sv
// Front panel menu controller: power-up display, menu editing, save, alarm
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "fpm_defines.svh"

module fpm_menu_ctrl
  import fpm_pkg::*;
#(
  parameter int          NUM_PLL   = `FPM_NUM_PLL,
  parameter logic [31:0] IDLE_CYC  = `FPM_IDLE_CYC,
  parameter logic [31:0] PHASE_CYC = `FPM_PHASE_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  input  wire logic               keySelect,
  input  wire logic               horizLeft,
  input  wire logic               horizRight,
  input  wire logic               vertUp,
  input  wire logic               vertDown,
  input  wire logic [NUM_PLL-1:0] pllUnlock,
  input  wire fpm_settings_s      nvReadData,
  input  wire logic [7:0]         regAddr,
  input  wire logic [31:0]        regWrData,
  input  wire logic               regWrite,
  input  wire logic               regRead,
  output logic [31:0]             regRdData,
  output fpm_settings_s           hwSettings,
  output fpm_settings_s           dispSettings,
  output logic                    nvWrite,
  output fpm_settings_s           nvWriteData,
  output logic                    alarmLamp,
  output logic                    irq,
  output fpm_state_e              dispMode,
  output logic [3:0]              dispItem,
  output logic [2:0]              dispCursor,
  output logic                    dispSaveYes
);
  typedef struct packed {
    fpm_state_e           mode;
    logic [3:0]           item;
    logic [2:0]           cursor;
    logic                 saveYes;
    logic [31:0]          timer;
    fpm_settings_s        stored;
    fpm_settings_s        edit;
    fpm_settings_s        hw;
    logic                 nvWrite;
    logic                 alarm;
    logic [`FPM_NST-1:0]  status;
    logic [`FPM_NST-1:0]  enable;
    logic                 irq;
    logic [31:0]          rdData;
  } fpm_ctl_s;
  localparam fpm_settings_s RST_SET = '{
    upFreq: `FPM_RST_UPF, upInLvl: `FPM_RST_UPL, dnFreq: `FPM_RST_DNF, default: '0};
  fpm_evt_if           ev ();
  fpm_ctl_s            st;
  fpm_ctl_s            next_st;
  logic [`FPM_NST-1:0] setBits;
  logic [`FPM_NST-1:0] clrBits;
  logic                anyUnlock;
  logic                editing;
  logic                timeoutNow;
  logic                commitNow;
  logic                discardNow;
  logic                vertOnly;
  fpm_switch_events fpm_switch_events_inst (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .keySelect  (keySelect),
    .horizLeft  (horizLeft),
    .horizRight (horizRight),
    .vertUp     (vertUp),
    .vertDown   (vertDown),
    .ev         (ev)
  );
  // Step size of the digit under the cursor; cursor 0 is the rightmost digit
  function automatic logic signed [15:0] digitStep(input logic [2:0] cur);
    case (cur)
      3'h0:    digitStep = 16'sh0001;
      3'h1:    digitStep = 16'sh000a;
      3'h2:    digitStep = 16'sh0064;
      default: digitStep = 16'sh03e8;
    endcase
  endfunction
  // One vertical actuation on the current item, clamped to its range
  function automatic fpm_settings_s adjust(input fpm_settings_s s, input logic [3:0] it,
                                           input logic [2:0] cur, input logic up);
    logic signed [15:0] v;
    logic signed [15:0] stp;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    v   = 16'sh0000;
    stp = digitStep(cur);
    lo  = 16'sh0000;
    hi  = 16'sh0000;
    case (it)
      `FPM_IT_UPF: begin
        v  = 16'(s.upFreq);
        lo = `FPM_UPF_MIN;
        hi = `FPM_UPF_MAX;
      end
      `FPM_IT_UPL: begin
        v   = 16'(s.upInLvl);
        stp = 16'sh0001;
        lo  = `FPM_INL_MIN;
        hi  = `FPM_INL_MAX;
      end
      `FPM_IT_UPG: begin
        v  = 16'(s.upGain);
        lo = `FPM_UPG_MIN;
        hi = `FPM_UPG_MAX;
      end
      `FPM_IT_DNF: begin
        v  = 16'(s.dnFreq);
        lo = `FPM_DNF_MIN;
        hi = `FPM_DNF_MAX;
      end
      `FPM_IT_DNG, `FPM_IT_BADR: begin
        v   = (it == `FPM_IT_DNG) ? 16'(s.dnGain) : 16'(s.busAddr);
        stp = (cur == 3'h0) ? 16'sh0001 : 16'sh000a;
        hi  = (it == `FPM_IT_DNG) ? `FPM_DNG_MAX : `FPM_ADR_MAX;
      end
      default: begin
        stp = 16'sh0000;
      end
    endcase
    // Raise or lower, then hold the value inside its range
    v = up ? v + stp : v - stp;
    if (v < lo) begin
      v = lo;
    end else if (v > hi) begin
      v = hi;
    end
    case (it)
      `FPM_IT_UPF:   s.upFreq   = v[11:0];
      `FPM_IT_UPL:   s.upInLvl  = v[7:0];
      `FPM_IT_UPG:   s.upGain   = v[7:0];
      `FPM_IT_DNF:   s.dnFreq   = v[11:0];
      `FPM_IT_DNG:   s.dnGain   = v[7:0];
      `FPM_IT_BADR:  s.busAddr  = v[7:0];
      // On/off items invert whichever way the switch moves
      `FPM_IT_MUTE:  s.upMute   = ~s.upMute;
      `FPM_IT_REM:   s.remote   = ~s.remote;
      `FPM_IT_SPEC:  s.specInv  = ~s.specInv;
      `FPM_IT_EXTR:  s.extRef   = ~s.extRef;
      `FPM_IT_UREF:  s.upRefOut = ~s.upRefOut;
      `FPM_IT_DREF:  s.dnRefOut = ~s.dnRefOut;
      `FPM_IT_BMODE: s.busMode  = ~s.busMode;
      default:       s = s;
    endcase
    return s;
  endfunction
  // Decoded conditions shared by the next-state logic and the checks
  assign anyUnlock  = |pllUnlock;
  assign editing    = (st.mode == FPM_MENU) || (st.mode == FPM_SAVE);
  assign timeoutNow = editing && !ev.any && (st.timer >= IDLE_CYC - 32'h1);
  assign commitNow  = (st.mode == FPM_SAVE) && ev.sel && st.saveYes;
  assign discardNow = (st.mode == FPM_SAVE) && ev.sel && !st.saveYes;
  assign vertOnly   = (ev.up || ev.down) && !ev.sel && !ev.left && !ev.right;
  // Whole controller: menu walk, editing, commit, alarm and register port
  always_comb begin
    next_st         = st;
    next_st.nvWrite = 1'b0;
    next_st.rdData  = 32'h0;
    next_st.timer   = st.timer + 32'h1;
    setBits         = '0;
    clrBits         = '0;
    case (st.mode)
      FPM_LOAD: begin
        // Settings captured from storage one edge after reset release
        next_st.stored = nvReadData;
        next_st.edit   = nvReadData;
        next_st.hw     = nvReadData;
        next_st.timer  = 32'h0;
        next_st.mode   = FPM_SEG;
      end
      FPM_SEG: begin
        if (st.timer >= PHASE_CYC - 32'h1) begin
          next_st.mode  = FPM_VER;
          next_st.timer = 32'h0;
        end
      end
      FPM_VER: begin
        if (st.timer >= PHASE_CYC - 32'h1) begin
          next_st.mode                = FPM_NORM;
          setBits[`FPM_ST_READY] = 1'b1;
        end
      end
      FPM_NORM: begin
        next_st.timer = 32'h0;
        if (ev.sel) begin
          // An edit always starts from the stored values
          next_st.mode   = FPM_MENU;
          next_st.item   = `FPM_IT_UPF;
          next_st.cursor = 3'h0;
          next_st.edit   = st.stored;
        end
      end
      FPM_MENU: begin
        if (ev.sel) begin
          if (st.cursor == `FPM_CUR_R || st.item == `FPM_IT_LAST) begin
            next_st.mode    = FPM_SAVE;
            next_st.saveYes = 1'b1;
          end else begin
            next_st.item = st.item + 4'h1;
          end
          next_st.cursor = 3'h0;
        end else if (ev.left && st.cursor != `FPM_CUR_R) begin
          next_st.cursor = st.cursor + 3'h1;
        end else if (ev.right && st.cursor != 3'h0) begin
          next_st.cursor = st.cursor - 3'h1;
        end else if (vertOnly && st.cursor != `FPM_CUR_R) begin
          next_st.edit = adjust(st.edit, st.item, st.cursor, ev.up);
        end
        // Level and gain go live, frequencies wait for the save
        next_st.hw.upInLvl = next_st.edit.upInLvl;
        next_st.hw.upGain  = next_st.edit.upGain;
        next_st.hw.dnGain  = next_st.edit.dnGain;
      end
      FPM_SAVE: begin
        if (commitNow) begin
          next_st.stored  = st.edit;
          next_st.hw      = st.edit;
          next_st.nvWrite = 1'b1;
          next_st.mode    = FPM_NORM;
          setBits[`FPM_ST_SAVED] = 1'b1;
        end else if (discardNow) begin
          next_st.edit = st.stored;
          next_st.hw   = st.stored;
          next_st.mode = FPM_NORM;
          setBits[`FPM_ST_DROP] = 1'b1;
        end else if (ev.up || ev.down || ev.left || ev.right) begin
          next_st.saveYes = ~st.saveYes;
        end
      end
      default: begin
        next_st.mode = FPM_LOAD;
      end
    endcase
    // Any switch activity restarts the idle count while editing
    if (editing && ev.any) begin
      next_st.timer = 32'h0;
    end
    if (timeoutNow) begin
      next_st.mode = FPM_NORM;
      next_st.edit = st.stored;
      next_st.hw   = st.stored;
      setBits[`FPM_ST_DROP] = 1'b1;
    end
    next_st.alarm = anyUnlock;
    setBits[`FPM_ST_UNLOCK] = anyUnlock && !st.alarm;
    // Register writes; decode is exact so other addresses are ignored
    if (regWrite) begin
      if (regAddr == `FPM_REG_CLEAR) begin
        clrBits = regWrData[`FPM_NST-1:0];
      end else if (regAddr == `FPM_REG_ENABLE) begin
        next_st.enable = regWrData[`FPM_NST-1:0];
      end
    end
    // A new event outranks a clear written in the same cycle
    next_st.status = (st.status & ~clrBits) | setBits;
    next_st.irq    = |(next_st.status & next_st.enable);
    // Reads answer next cycle; unmapped and write-only read as zero
    if (regRead) begin
      if (regAddr == `FPM_REG_STATUS) begin
        next_st.rdData = 32'(st.status);
      end else if (regAddr == `FPM_REG_ENABLE) begin
        next_st.rdData = 32'(st.enable);
      end else if (regAddr == `FPM_REG_VIEW) begin
        next_st.rdData = 32'({st.alarm, st.saveYes, st.cursor, st.item, st.mode});
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st        <= '0;
      st.mode   <= FPM_LOAD;
      st.stored <= RST_SET;
      st.edit   <= RST_SET;
      st.hw     <= RST_SET;
    end else begin
      st <= next_st;
    end
  end
  // Every output is a field of the state register
  assign regRdData    = st.rdData;
  assign hwSettings   = st.hw;
  assign dispSettings = st.edit;
  assign nvWrite      = st.nvWrite;
  assign nvWriteData  = st.stored;
  assign alarmLamp    = st.alarm;
  assign irq          = st.irq;
  assign dispMode     = st.mode;
  assign dispItem     = st.item;
  assign dispCursor   = st.cursor;
  assign dispSaveYes  = st.saveYes;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence sSegDone;
    st.mode == FPM_SEG && st.timer >= PHASE_CYC - 32'h1;
  endsequence
  sequence sVerDone;
    st.mode == FPM_VER && st.timer >= PHASE_CYC - 32'h1;
  endsequence

  AST_SEG_THEN_VER: assert property (sSegDone |=> st.mode == FPM_VER)
    else $error("segment phase not followed by version");
  AST_VER_THEN_NORM: assert property (sVerDone |=> st.mode == FPM_NORM)
    else $error("version phase not followed by normal display");
  AST_STORE_ONLY_ON_YES: assert property (!$stable(st.stored) |-> $past(commitNow) || $past(st.mode) == FPM_LOAD)
    else $error("stored settings changed without a confirmed save");
  AST_COMMIT: assert property (commitNow |=> nvWrite && st.stored == $past(st.edit) ##1 !nvWrite)
    else $error("yes did not commit pending settings");
  AST_DISCARD: assert property (discardNow |=> st.hw == st.stored && st.edit == st.stored && !nvWrite)
    else $error("no did not restore prior settings");
  AST_TIMEOUT: assert property (timeoutNow |=> st.mode == FPM_NORM && st.hw == st.stored)
    else $error("timeout did not abandon the edit");
  AST_IDLE_BOUND: assert property (editing |-> st.timer < IDLE_CYC)
    else $error("idle count ran past the limit");
  AST_FREQ_HELD: assert property (st.mode == FPM_MENU |-> st.hw.upFreq == st.stored.upFreq && st.hw.dnFreq == st.stored.dnFreq)
    else $error("frequency applied before save");
  AST_GAIN_LIVE: assert property (st.mode == FPM_MENU |-> st.hw.upGain == st.edit.upGain && st.hw.upInLvl == st.edit.upInLvl)
    else $error("gain or level not applied at once");
  AST_CURSOR_LEFT: assert property (st.mode == FPM_MENU && ev.left && !ev.sel && st.cursor < `FPM_CUR_R
                                    |=> st.cursor == $past(st.cursor) + 3'h1)
    else $error("cursor did not move one digit");
  AST_MUTE_TOGGLE: assert property (st.mode == FPM_MENU && st.item == `FPM_IT_MUTE && vertOnly && st.cursor != `FPM_CUR_R
                                    |=> st.edit.upMute != $past(st.edit.upMute))
    else $error("mute did not toggle");
  AST_DNG_TENS: assert property (st.mode == FPM_MENU && st.item == `FPM_IT_DNG && vertOnly && ev.up && st.cursor == 3'h1
                                 && st.edit.dnGain <= 8'h28 |=> st.edit.dnGain == $past(st.edit.dnGain) + 8'h0a)
    else $error("down gain tens step wrong");
  AST_LEVEL_RANGE: assert property (16'(st.edit.upInLvl) >= `FPM_INL_MIN && 16'(st.edit.upInLvl) <= `FPM_INL_MAX)
    else $error("input level out of range");
  AST_UPG_RANGE: assert property ($signed(st.edit.upGain) >= -8'sh0a && $signed(st.edit.upGain) <= 8'sh1e)
    else $error("up gain out of range");
  AST_DNG_RANGE: assert property (st.edit.dnGain <= 8'h32)
    else $error("down gain out of range");
  AST_RETURN: assert property (st.mode == FPM_MENU && ev.sel && st.cursor == `FPM_CUR_R |=> st.mode == FPM_SAVE)
    else $error("return marker did not reach save item");
  AST_ITEM_ORDER: assert property (st.mode == FPM_MENU && ev.sel && st.cursor != `FPM_CUR_R && st.item != `FPM_IT_LAST
                                   |=> st.item == $past(st.item) + 4'h1)
    else $error("menu item order broken");
  AST_ALARM: assert property (anyUnlock |=> alarmLamp)
    else $error("alarm lamp not lit on lock loss");
endmodule // fpm_menu_ctrl

// File: fpm_defines.svh
// Constants for the front panel menu controller
`ifndef FPM_DEFINES_SVH
`define FPM_DEFINES_SVH
`define FPM_CLK_HZ     32'h0bebc200
`define FPM_IDLE_S     32'h0000000c
`define FPM_IDLE_CYC   (32'(64'(`FPM_IDLE_S) * 64'(`FPM_CLK_HZ)))
`define FPM_PHASE_MS   32'h000003e8
`define FPM_PHASE_CYC  (32'(64'(`FPM_PHASE_MS) * 64'(`FPM_CLK_HZ) / 64'h3e8))
`define FPM_NUM_PLL    2
`define FPM_REG_STATUS 8'h00
`define FPM_REG_CLEAR  8'h04
`define FPM_REG_ENABLE 8'h08
`define FPM_REG_VIEW   8'h0c
`define FPM_NST        4
`define FPM_ST_UNLOCK  0
`define FPM_ST_SAVED   1
`define FPM_ST_DROP    2
`define FPM_ST_READY   3
`define FPM_IT_UPF     4'h1
`define FPM_IT_UPL     4'h2
`define FPM_IT_UPG     4'h3
`define FPM_IT_DNF     4'h4
`define FPM_IT_DNG     4'h5
`define FPM_IT_MUTE    4'h6
`define FPM_IT_REM     4'h7
`define FPM_IT_SPEC    4'h8
`define FPM_IT_EXTR    4'h9
`define FPM_IT_UREF    4'ha
`define FPM_IT_DREF    4'hb
`define FPM_IT_BMODE   4'hc
`define FPM_IT_BADR    4'hd
`define FPM_IT_LAST    4'hf
`define FPM_CUR_R      3'h4
`define FPM_UPF_MIN    16'sh07d0
`define FPM_UPF_MAX    16'sh09c4
`define FPM_DNF_MIN    16'sh03b6
`define FPM_DNF_MAX    16'sh05f5
`define FPM_INL_MIN    (-16'sh0028)
`define FPM_INL_MAX    (-16'sh000a)
`define FPM_UPG_MIN    (-16'sh000a)
`define FPM_UPG_MAX    16'sh001e
`define FPM_DNG_MIN    16'sh0000
`define FPM_DNG_MAX    16'sh0032
`define FPM_ADR_MAX    16'sh0063
`define FPM_RST_UPF    12'h7d0
`define FPM_RST_UPL    8'hec
`define FPM_RST_DNF    12'h3b6
`endif

// File: fpm_pkg.sv
// Types shared by the front panel menu controller
package fpm_pkg;
  typedef enum logic [5:0] {
    FPM_LOAD = 6'h01,
    FPM_SEG  = 6'h02,
    FPM_VER  = 6'h04,
    FPM_NORM = 6'h08,
    FPM_MENU = 6'h10,
    FPM_SAVE = 6'h20
  } fpm_state_e;

  typedef struct packed {
    logic [11:0]       upFreq;
    logic signed [7:0] upInLvl;
    logic signed [7:0] upGain;
    logic [11:0]       dnFreq;
    logic [7:0]        dnGain;
    logic              upMute;
    logic              remote;
    logic              specInv;
    logic              extRef;
    logic              upRefOut;
    logic              dnRefOut;
    logic              busMode;
    logic [7:0]        busAddr;
  } fpm_settings_s;
endpackage

// File: fpm_evt_if.sv
// Switch event bundle between the switch front end and the menu core
`timescale 1ns/1ps
interface fpm_evt_if;
  logic sel;
  logic left;
  logic right;
  logic up;
  logic down;
  logic any;
  modport src (output sel, left, right, up, down, any);
  modport dst (input sel, left, right, up, down, any);
endinterface

// File: fpm_switch_events.sv
// Turns the three operator switches into one-cycle press events
`timescale 1ns/1ps
module fpm_switch_events
  import fpm_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic keySelect,
  input  wire logic horizLeft,
  input  wire logic horizRight,
  input  wire logic vertUp,
  input  wire logic vertDown,
  fpm_evt_if.src    ev
);
  typedef struct packed {
    logic [4:0] prev;
    logic [4:0] rise;
  } fpm_sw_s;

  fpm_sw_s    st;
  fpm_sw_s    next_st;
  logic [4:0] raw;

  // A held switch counts once: only the press edge is an event
  always_comb begin
    raw = {vertDown, vertUp, horizRight, horizLeft, keySelect};
    next_st = st;
    next_st.prev = raw;
    next_st.rise = raw & ~st.prev;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ev.sel   = st.rise[0];
  assign ev.left  = st.rise[1];
  assign ev.right = st.rise[2];
  assign ev.up    = st.rise[3];
  assign ev.down  = st.rise[4];
  assign ev.any   = |st.rise;

  AST_LEFT_EDGE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(horizLeft) |=> ev.left) else $error("left press lost");
endmodule // fpm_switch_events

// File: fpm_nv_store.sv
// Nonvolatile settings store model standing beside the menu controller
`timescale 1ns/1ps
module fpm_nv_store
  import fpm_pkg::*;
#(
  parameter fpm_settings_s INIT = '0
) (
  input  wire logic          sys_clk,
  input  wire logic          nvWrite,
  input  wire fpm_settings_s nvWriteData,
  output fpm_settings_s      nvReadData
);
  // No reset on purpose: contents must outlive a controller power cycle
  initial nvReadData = INIT;

  // Contents change only on a confirmed save, never on live edits
  always @(posedge sys_clk) begin
    if (nvWrite === 1'b1) begin
      nvReadData <= nvWriteData;
    end
  end
endmodule // fpm_nv_store

// File: fpm_menu_ctrl_bench.sv
// Self-checking bench for the front panel menu controller
`timescale 1ns/1ps
`include "fpm_defines.svh"
module fpm_menu_ctrl_bench;
  import fpm_pkg::*;
  localparam int SEL = 0;
  localparam int LFT = 1;
  localparam int RGT = 2;
  localparam int UP  = 3;
  localparam int DN  = 4;
  localparam int IDLE  = 200;
  localparam int PHASE = 8;
  // Stored settings at power-up, away from the controller defaults
  localparam fpm_settings_s INIT = '{upFreq: 12'h834, upInLvl: 8'hec, upGain: 8'h05, dnFreq: 12'h3e8,
                                     dnGain: 8'h14, default: '0};
  logic          sys_clk;
  logic          reset_n;
  logic [4:0]    sw;
  logic [1:0]    pllUnlock;
  logic [7:0]    regAddr;
  logic [31:0]   regWrData;
  logic          regWrite;
  logic          regRead;
  logic [31:0]   regRdData;
  fpm_settings_s nvReadData, hwSettings, dispSettings, nvWriteData;
  logic          nvWrite, alarmLamp, irq, dispSaveYes;
  fpm_state_e    dispMode;
  logic [3:0]    dispItem;
  logic [2:0]    dispCursor;
  int            errCount;
  int            nChecks;

  fpm_menu_ctrl #(.NUM_PLL(2), .IDLE_CYC(32'(IDLE)), .PHASE_CYC(32'(PHASE))) fpm_menu_ctrl_inst (
    .sys_clk, .reset_n, .keySelect(sw[SEL]), .horizLeft(sw[LFT]), .horizRight(sw[RGT]),
    .vertUp(sw[UP]), .vertDown(sw[DN]), .pllUnlock, .nvReadData, .regAddr, .regWrData, .regWrite,
    .regRead, .regRdData, .hwSettings, .dispSettings, .nvWrite, .nvWriteData, .alarmLamp, .irq,
    .dispMode, .dispItem, .dispCursor, .dispSaveYes);

  fpm_nv_store #(.INIT(INIT)) fpm_nv_store_inst (.sys_clk, .nvWrite, .nvWriteData, .nvReadData);

  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkSet(input fpm_settings_s got, input fpm_settings_s exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One press: level up for one cycle, result settled two edges later
  task automatic press(input int k);
    @(posedge sys_clk) sw[k] <= 1'b1;
    @(posedge sys_clk) sw[k] <= 1'b0;
    @(posedge sys_clk) #1;
  endtask

  // Right at the rightmost digit is ignored, so four presses park the cursor
  task automatic curHome();
    repeat (4) press(RGT);
  endtask

  task automatic regWr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge sys_clk) regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic regRdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk) regRead <= 1'b0;
    #1 chk(regRdData, e);
  endtask

  // Power cycle: reset, then the two display phases; presses in them are dropped
  task automatic boot(input fpm_settings_s e);
    @(posedge sys_clk) reset_n <= 1'b0;
    repeat (4) @(posedge sys_clk);  // Reset is seen low on five edges in all
    #1 chk(32'(dispMode), 32'(FPM_LOAD));
    @(posedge sys_clk) reset_n <= 1'b1;
    @(posedge sys_clk) #1 chk(32'(dispMode), 32'(FPM_SEG));
    chkSet(hwSettings, e);
    press(SEL);
    chk(32'(dispMode), 32'(FPM_SEG));
    repeat (PHASE) @(posedge sys_clk);
    #1 chk(32'(dispMode), 32'(FPM_VER));
    repeat (PHASE) @(posedge sys_clk);
    #1 chk(32'(dispMode), 32'(FPM_NORM));
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    errCount++;
    reportAndStop();
  end

  // Main sequence
  initial begin
    fpm_settings_s exp;
    sw = '0;
    pllUnlock = '0;
    regAddr = '0;
    regWrData = '0;
    regWrite = 1'b0;
    regRead = 1'b0;
    reset_n = 1'b0;
    errCount = 0;
    nChecks = 0;
    boot(INIT);
    regRdChk(`FPM_REG_STATUS, 32'h8);
    regWr(`FPM_REG_ENABLE, 32'h2);
    regRdChk(`FPM_REG_ENABLE, 32'h2);
    regRdChk(8'h40, 32'h0);
    regWr(`FPM_REG_CLEAR, 32'h8);
    // Walk the menu, editing live and deferred items
    press(SEL);
    chk(32'(dispMode), 32'(FPM_MENU));
    chk(32'(dispItem), 1);
    press(SEL);
    press(DN);
    chk(32'(hwSettings.upInLvl), -21);
    repeat (20) press(DN);
    chk(32'(hwSettings.upInLvl), -40);
    chk(32'(nvWriteData.upInLvl), -20);
    press(SEL);
    curHome();
    press(UP);
    chk(32'(dispSettings.upGain), 6);
    press(LFT);
    chk(32'(dispCursor), 1);
    press(UP);
    chk(32'(hwSettings.upGain), 16);
    repeat (2) press(UP);
    chk(32'(hwSettings.upGain), 30);
    press(SEL);
    curHome();
    press(UP);
    chk(32'(dispSettings.dnFreq), 1001);
    chk(32'(hwSettings.dnFreq), 1000);
    press(SEL);
    curHome();
    press(UP);
    chk(32'(hwSettings.dnGain), 21);
    press(LFT);
    press(UP);
    chk(32'(hwSettings.dnGain), 31);
    repeat (2) press(UP);
    chk(32'(hwSettings.dnGain), 50);
    press(SEL);
    press(UP);
    chk(32'(dispSettings.upMute), 1);
    press(DN);
    chk(32'(dispSettings.upMute), 0);
    press(DN);
    chk(32'(dispSettings.upMute), 1);
    for (int i = 7; i <= 15; i++) begin
      press(SEL);
      chk(32'(dispItem), i);
      // Remote is an on/off item, bus address a numeric one
      if (i == 7 || i == 13) begin
        press(UP);
      end
    end
    chk(32'(dispSettings.remote), 1);
    chk(32'(hwSettings.remote), 0);
    chk(32'(dispSettings.busAddr), 1);
    press(SEL);
    chk(32'(dispMode), 32'(FPM_SAVE));
    chk(32'(dispSaveYes), 1);
    // Confirm yes: everything pending is committed and stored
    press(SEL);
    chk(32'(nvWrite), 1);
    exp = INIT;
    exp.upInLvl = 8'hd8;
    exp.upGain = 8'h1e;
    exp.dnFreq = 12'h3e9;
    exp.dnGain = 8'h32;
    exp.upMute = 1'b1;
    exp.remote = 1'b1;
    exp.busAddr = 8'h01;
    chkSet(nvWriteData, exp);
    chkSet(hwSettings, exp);
    regWr(`FPM_REG_STATUS, 32'hf);
    regRdChk(`FPM_REG_STATUS, 32'h2);
    chk(32'(irq), 1);
    regWr(`FPM_REG_ENABLE, 32'h0);
    @(posedge sys_clk) #1 chk(32'(irq), 0);
    regWr(`FPM_REG_CLEAR, 32'h2);
    regRdChk(`FPM_REG_STATUS, 32'h0);
    // Leave through the return marker and answer no
    press(SEL);
    curHome();
    press(UP);
    chk(32'(dispSettings.upFreq), 2101);
    repeat (4) press(LFT);
    chk(32'(dispCursor), 32'(`FPM_CUR_R));
    press(UP);
    chk(32'(dispSettings.upFreq), 2101);
    press(SEL);
    chk(32'(dispMode), 32'(FPM_SAVE));
    regRdChk(`FPM_REG_VIEW, 32'h2060);
    press(DN);
    chk(32'(dispSaveYes), 0);
    press(SEL);
    chkSet(dispSettings, exp);
    chkSet(hwSettings, exp);
    regRdChk(`FPM_REG_STATUS, 32'h4);
    regWr(`FPM_REG_CLEAR, 32'h4);
    // Idle timeout abandons a live level edit
    press(SEL);
    press(SEL);
    press(UP);
    chk(32'(hwSettings.upInLvl), -39);
    repeat (IDLE - 10) @(posedge sys_clk);
    #1 chk(32'(dispMode), 32'(FPM_MENU));
    repeat (20) @(posedge sys_clk);
    #1 chk(32'(dispMode), 32'(FPM_NORM));
    chk(32'(hwSettings.upInLvl), -40);
    regRdChk(`FPM_REG_STATUS, 32'h4);
    // Each loop losing lock lights the lamp and raises the interrupt
    regWr(`FPM_REG_ENABLE, 32'h1);
    for (int b = 0; b < 2; b++) begin
      @(posedge sys_clk) pllUnlock[b] <= 1'b1;
      @(posedge sys_clk) #1 chk(32'(alarmLamp), 1);
      regRdChk(`FPM_REG_STATUS, 32'h5);
      chk(32'(irq), 1);
      @(posedge sys_clk) pllUnlock <= '0;
      @(posedge sys_clk) #1 chk(32'(alarmLamp), 0);
      regWr(`FPM_REG_CLEAR, 32'h1);
    end
    // Second power cycle resumes with the committed settings
    boot(exp);
    reportAndStop();
  end
endmodule // fpm_menu_ctrl_bench
